/* src/ascs_pkg.sv */
// Purpose: Shared constants, tables and types of the audio serial port
//          clock and channel 8 slot configuration block.
// Assumes: Register offsets and reset values as seen by the control port.
// Notes:   Frequencies are held in hertz, bit counts in bit clock cycles.
package ascs_pkg;

  // Register offsets on the control port.
  localparam logic [7:0] ADDR_CHAN_EIGHT_SLOT_SELECT = 8'h12;
  localparam logic [7:0] ADDR_MASTER_CLOCK_CONFIG_ZERO = 8'h13;
  localparam logic [7:0] ADDR_MASTER_CLOCK_CONFIG_ONE = 8'h14;

  // Register reset values.
  localparam logic [7:0] RST_CHAN_EIGHT_SLOT_SELECT = 8'h07;
  localparam logic [7:0] RST_MASTER_CLOCK_CONFIG_ZERO = 8'h02;
  localparam logic [7:0] RST_MASTER_CLOCK_CONFIG_ONE = 8'h48;

  // Field positions.
  localparam int CH8_RSVD_BIT = 7;
  localparam int CH8_LINE_BIT = 6;
  localparam int ROLE_BIT = 7;
  localparam int AUTO_BIT = 6;
  localparam int PLL_OFF_BIT = 5;
  localparam int GATE_BIT = 4;
  localparam int FAMILY_BIT = 3;
  localparam int RATE_MSB = 7;
  localparam int RATE_LSB = 4;
  localparam int RATIO_MSB = 3;
  localparam int RATIO_LSB = 0;

  // Highest legal codes; anything above is reserved.
  localparam logic [3:0] RATE_MAX = 4'h8;
  localparam logic [3:0] RATIO_MAX = 4'hC;

  // Bit positions within a frame need 12 bits for a 2048-bit frame.
  localparam int BITS_W = 12;
  localparam int SAMPLE_W = 32;
  localparam logic [BITS_W-1:0] BITS_ONE = 12'h001;

  // Serial framing formats, set by the port format logic outside.
  typedef enum logic [1:0] {
    ASCS_TDM = 2'b00,
    ASCS_I2S = 2'b01,
    ASCS_LJ = 2'b10
  } ascs_fmt_e;

  // Decoded register contents.
  typedef struct packed {
    logic role;
    logic auto_off;
    logic pll_off;
    logic gate;
    logic family;
    logic [2:0] ref_code;
    logic [3:0] rate;
    logic [3:0] ratio;
    logic out_line;
    logic [5:0] slot;
  } ascs_cfg_s;

  // Sample rates of the 48 kHz family, 8 kHz to 768 kHz.
  localparam logic [31:0] FS48_HZ [0:8] = '{
    32'h00001F40, 32'h00003E80, 32'h00005DC0, 32'h00007D00, 32'h0000BB80,
    32'h00017700, 32'h0002EE00, 32'h0005DC00, 32'h000BB800};
  // Sample rates of the 44.1 kHz family, 7.35 kHz to 705.6 kHz.
  localparam logic [31:0] FS441_HZ [0:8] = '{
    32'h00001CB6, 32'h0000396C, 32'h00005622, 32'h000072D8, 32'h0000AC44,
    32'h00015888, 32'h0002B110, 32'h00056220, 32'h000AC440};
  // Bit clocks per frame, 16 to 2048.
  localparam logic [BITS_W-1:0] RATIO_BITS [0:12] = '{
    12'h010, 12'h018, 12'h020, 12'h030, 12'h040, 12'h060, 12'h080,
    12'h0C0, 12'h100, 12'h180, 12'h200, 12'h400, 12'h800};
  // Reference clock frequencies, 12 MHz to 24.576 MHz.
  localparam logic [31:0] REF_HZ [0:7] = '{
    32'h00B71B00, 32'h00BB8000, 32'h00C65D40, 32'h00F42400,
    32'h0124F800, 32'h012C4B00, 32'h016E3600, 32'h01770000};
  // Reference clock to frame sync ratios, 64 to 2304.
  localparam logic [BITS_W-1:0] REF_RATIO [0:7] = '{
    12'h040, 12'h100, 12'h180, 12'h200, 12'h300, 12'h400, 12'h600,
    12'h900};

endpackage

/* src/ascs_regs.sv */
// Purpose: Control port register file for channel 8 slot and master clocks.
// Assumes: One access per request, read data valid one cycle later.
// Notes:   Unmapped offsets ignore writes and read as zero.
`timescale 1ns/10ps
module ascs_regs (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Control port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Decoded configuration.
  output ascs_pkg::ascs_cfg_s cfg
);
  logic [6:0] ch8;
  logic [7:0] cfg0;
  logic [7:0] cfg1;

  // Address decode and read selection.
  wire hit_ch8 = reg_addr == ascs_pkg::ADDR_CHAN_EIGHT_SLOT_SELECT;
  wire hit_cfg0 = reg_addr == ascs_pkg::ADDR_MASTER_CLOCK_CONFIG_ZERO;
  wire hit_cfg1 = reg_addr == ascs_pkg::ADDR_MASTER_CLOCK_CONFIG_ONE;
  wire [7:0] rd_mux = hit_ch8 ? {1'b0, ch8} :
                      hit_cfg0 ? cfg0 :
                      hit_cfg1 ? cfg1 : 8'h00;

  // Writes. The reserved top bit of the slot register has no storage.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ch8 <= ascs_pkg::RST_CHAN_EIGHT_SLOT_SELECT[6:0];
      cfg0 <= ascs_pkg::RST_MASTER_CLOCK_CONFIG_ZERO;
      cfg1 <= ascs_pkg::RST_MASTER_CLOCK_CONFIG_ONE;
    end else if (reg_wr) begin
      if (hit_ch8) ch8 <= reg_wdata[6:0];
      if (hit_cfg0) cfg0 <= reg_wdata;
      if (hit_cfg1) cfg1 <= reg_wdata;
    end
  end

  // Registered read answer.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      reg_rvalid <= reg_rd;
    end
  end

  // Field split.
  assign cfg.role = cfg0[ascs_pkg::ROLE_BIT];
  assign cfg.auto_off = cfg0[ascs_pkg::AUTO_BIT];
  assign cfg.pll_off = cfg0[ascs_pkg::PLL_OFF_BIT];
  assign cfg.gate = cfg0[ascs_pkg::GATE_BIT];
  assign cfg.family = cfg0[ascs_pkg::FAMILY_BIT];
  assign cfg.ref_code = cfg0[2:0];
  assign cfg.rate = cfg1[ascs_pkg::RATE_MSB:ascs_pkg::RATE_LSB];
  assign cfg.ratio = cfg1[ascs_pkg::RATIO_MSB:ascs_pkg::RATIO_LSB];
  assign cfg.out_line = ch8[ascs_pkg::CH8_LINE_BIT];
  assign cfg.slot = ch8[5:0];
endmodule // ascs_regs

/* src/ascs_frame_cnt.sv */
// Purpose: Bit position counter within one serial frame.
// Assumes: step is a one-cycle pulse per bit clock falling edge.
// Notes:   A zero length holds the counter at bit zero.
`timescale 1ns/10ps
module ascs_frame_cnt (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Control.
  input wire logic start,
  input wire logic step,
  input wire logic [ascs_pkg::BITS_W-1:0] frame_len,
  // Position.
  output logic [ascs_pkg::BITS_W-1:0] bit_idx
);
  wire last_bit = (frame_len == '0) ||
                  (bit_idx >= frame_len - ascs_pkg::BITS_ONE);
  wire [ascs_pkg::BITS_W-1:0] next_idx =
    last_bit ? '0 : bit_idx + ascs_pkg::BITS_ONE;

  // Start wins over a step so a new frame always begins at bit zero.
  always_ff @(posedge clk) begin
    if (sys_rst || start) begin
      bit_idx <= '0;
    end else if (step) begin
      bit_idx <= next_idx;
    end
  end
endmodule // ascs_frame_cnt

/* src/ascs_top.sv */
// Purpose: Audio serial port clocking and channel 8 slot placement.
// Assumes: Pins are synchronous to clk; half_bit_tick comes from the audio
//          root divider and is at least two clk cycles apart.
// Notes:   Outputs settle one clk after each bit clock falling edge in master role, two clk after a falling bclk_in in slave role.
`timescale 1ns/10ps
module ascs_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Control port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Port setup held outside this block.
  input wire ascs_pkg::ascs_fmt_e fmt,
  input wire logic [5:0] word_bits,
  input wire logic ref_clock_spec_mode,
  input wire logic [2:0] ref_ratio_sel,
  input wire logic custom_pll_en,
  // Audio root timing and sample.
  input wire logic half_bit_tick,
  input wire logic [ascs_pkg::SAMPLE_W-1:0] ch8_sample,
  output logic sample_taken,
  // Serial pins.
  input wire logic bclk_in,
  output logic bclk_out,
  output logic bclk_oe,
  input wire logic frame_sync_in,
  output logic frame_sync_out,
  output logic frame_sync_oe,
  output logic primary_serial_out,
  output logic primary_serial_oe,
  output logic secondary_serial_out,
  output logic secondary_serial_oe,
  // Clock plan status.
  output logic auto_derive,
  output logic pll_enable,
  output logic [31:0] fs_hz,
  output logic [31:0] bclk_freq_hz,
  output logic [31:0] ref_freq_hz,
  output logic config_error
);
  localparam int BW = ascs_pkg::BITS_W;
  ascs_pkg::ascs_cfg_s cfg;
  logic bclk_q;
  logic bclk_in_d;
  logic fs_in_d;
  logic step_d;
  logic [BW-1:0] meas_len;
  logic [BW-1:0] bit_idx;
  logic [ascs_pkg::SAMPLE_W-1:0] samp_q;

  ascs_regs u_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .cfg(cfg)
  );

  // Code checks and table lookups for the clock plan.
  wire master = cfg.role;
  wire slave_auto = !cfg.role && !cfg.auto_off;
  wire rate_ok = cfg.rate <= ascs_pkg::RATE_MAX;
  wire ratio_ok = cfg.ratio <= ascs_pkg::RATIO_MAX;
  wire [31:0] fs_sel = !rate_ok ? 32'h0 :
    cfg.family ? ascs_pkg::FS441_HZ[cfg.rate] :
    ascs_pkg::FS48_HZ[cfg.rate];
  wire [BW-1:0] ratio_len = ratio_ok ? ascs_pkg::RATIO_BITS[cfg.ratio] :
                            '0;
  wire [43:0] bclk_prod = fs_sel * ratio_len;
  wire [43:0] ref_prod = fs_sel * ascs_pkg::REF_RATIO[ref_ratio_sel];
  wire [31:0] next_ref = ref_clock_spec_mode ? ref_prod[31:0] :
                         ascs_pkg::REF_HZ[cfg.ref_code];
  wire next_pll = cfg.auto_off ? custom_pll_en : !cfg.pll_off;
  wire next_err = slave_auto ? 1'b0 : !(rate_ok && ratio_ok);

  // Bit clock events from the root divider or from the far end.
  wire run_m = master && rate_ok && ratio_ok;
  wire fall_m = run_m && half_bit_tick && bclk_q;
  wire fall_s = !master && bclk_in_d && !bclk_in;
  wire fs_rise_s = !master && !fs_in_d && frame_sync_in;
  wire step = master ? fall_m : fall_s;
  wire start = master ? !run_m : fs_rise_s;
  wire [BW-1:0] frame_len = slave_auto ? meas_len : ratio_len;
  // In slave automatic mode the counter runs free and only the incoming
  // frame sync restarts it; the length is unknown until it is measured,
  // so feeding the measured value back would lock the count at zero.
  wire [BW-1:0] cnt_len = slave_auto ? '1 : ratio_len;
  wire [BW-1:0] half_len = {1'b0, frame_len[BW-1:1]};

  // Slot placement; in two-channel formats the top slot bit picks right.
  wire [BW-1:0] wbits = {{(BW-6){1'b0}}, word_bits};
  wire [BW-1:0] slot_n = {{(BW-5){1'b0}}, cfg.slot[4:0]};
  wire [2*BW-1:0] lr_prod = slot_n * wbits;
  wire [BW-1:0] lr_base = (cfg.slot[5] ? half_len : '0) + lr_prod[BW-1:0];
  wire [2*BW-1:0] tdm_prod = {{(BW-6){1'b0}}, cfg.slot} * wbits;
  wire [BW-1:0] i2s_delay = fmt == ascs_pkg::ASCS_I2S ? ascs_pkg::BITS_ONE
                            : '0;
  wire [BW-1:0] slot_start = fmt == ascs_pkg::ASCS_TDM ? tdm_prod[BW-1:0]
                             : lr_base + i2s_delay;
  wire [BW-1:0] bit_off = bit_idx - slot_start;
  wire in_slot = (bit_idx >= slot_start) && (bit_off < wbits);
  wire [4:0] samp_pos = 5'(wbits - bit_off - ascs_pkg::BITS_ONE);
  // At bit zero the sample is latched on the same edge, so the fresh word
  // is used there; otherwise a slot at bit zero would mix two samples.
  wire [ascs_pkg::SAMPLE_W-1:0] cur_samp = bit_idx == '0 ? ch8_sample :
                                           samp_q;
  wire next_data = in_slot && cur_samp[samp_pos];

  // Frame sync shape: TDM pulses at bit zero, LJ is high on the left half,
  // I2S is low on the left half.
  wire next_frame_sync = fmt == ascs_pkg::ASCS_TDM ? bit_idx == '0 :
                    fmt == ascs_pkg::ASCS_LJ ? bit_idx < half_len :
                    bit_idx >= half_len;

  ascs_frame_cnt u_frame (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(start),
    .step(step),
    .frame_len(cnt_len),
    .bit_idx(bit_idx)
  );

  // Bit clock divider; it stops low when the master codes are unusable.
  always_ff @(posedge clk) begin
    if (sys_rst || !run_m) begin
      bclk_q <= 1'b0;
    end else if (half_bit_tick) begin
      bclk_q <= !bclk_q;
    end
  end

  // Incoming pin history and measured frame length in slave mode.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bclk_in_d <= 1'b0;
      fs_in_d <= 1'b0;
      meas_len <= '0;
      step_d <= 1'b0;
    end else begin
      bclk_in_d <= bclk_in;
      fs_in_d <= frame_sync_in;
      step_d <= step;
      if (fs_rise_s) meas_len <= bit_idx + ascs_pkg::BITS_ONE;
    end
  end

  // Sample capture at each frame start so a slot never mixes two samples.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      samp_q <= '0;
      sample_taken <= 1'b0;
    end else begin
      sample_taken <= step_d && bit_idx == '0;
      if (step_d && bit_idx == '0) samp_q <= ch8_sample;
    end
  end

  // Generated clock pins; the gate forces both low but keeps them driven.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bclk_out <= 1'b0;
      bclk_oe <= 1'b0;
      frame_sync_out <= 1'b0;
      frame_sync_oe <= 1'b0;
    end else begin
      bclk_out <= bclk_q && !cfg.gate;
      bclk_oe <= master;
      frame_sync_oe <= master;
      if (!master || cfg.gate) begin
        frame_sync_out <= 1'b0;
      end else if (step_d || !run_m) begin
        frame_sync_out <= run_m && next_frame_sync;
      end
    end
  end

  // Channel 8 data lands on one of the two serial lines only in its slot.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      primary_serial_out <= 1'b0;
      primary_serial_oe <= 1'b0;
      secondary_serial_out <= 1'b0;
      secondary_serial_oe <= 1'b0;
    end else if (step_d) begin
      primary_serial_out <= !cfg.out_line && next_data;
      primary_serial_oe <= !cfg.out_line && in_slot;
      secondary_serial_out <= cfg.out_line && next_data;
      secondary_serial_oe <= cfg.out_line && in_slot;
    end
  end

  // Clock plan status for the PLL and divider logic.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      auto_derive <= 1'b0;
      pll_enable <= 1'b0;
      fs_hz <= '0;
      bclk_freq_hz <= '0;
      ref_freq_hz <= '0;
      config_error <= 1'b0;
    end else begin
      auto_derive <= !cfg.auto_off;
      pll_enable <= next_pll;
      fs_hz <= fs_sel;
      bclk_freq_hz <= bclk_prod[31:0];
      ref_freq_hz <= next_ref;
      config_error <= next_err;
    end
  end

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  line_route_a: assert property (
    step_d && cfg.out_line |=> !primary_serial_oe)
    else $error("channel 8 left on the primary line");
  slot_place_a: assert property (
    step_d && in_slot && bit_idx == slot_start && !cfg.out_line
    |=> primary_serial_oe)
    else $error("channel 8 slot did not start on time");
  rsvd_zero_a: assert property (
    reg_rd && reg_addr == ascs_pkg::ADDR_CHAN_EIGHT_SLOT_SELECT |=> !reg_rdata[7])
    else $error("reserved slot bit read back as one");
  role_drive_a: assert property (
    ##1 bclk_oe == $past(master) && frame_sync_oe == $past(master))
    else $error("clock drive does not follow the role");
  pll_ctrl_a: assert property (
    !cfg.auto_off && cfg.pll_off ##1 !cfg.auto_off |-> !pll_enable)
    else $error("PLL left on in automatic mode");
  clk_gate_a: assert property (
    (master && cfg.gate) [*2] |-> !bclk_out && !frame_sync_out)
    else $error("generated clocks not gated");
  rate_family_a: assert property (
    cfg.rate == 4'h4 && cfg.family |=> fs_hz == 32'h0000AC44)
    else $error("wrong sample rate for the 44.1 kHz family");
  ref_freq_a: assert property (
    !ref_clock_spec_mode && cfg.ref_code == 3'h7
    |=> ref_freq_hz == 32'h01770000)
    else $error("wrong reference frequency");
  code_rsvd_a: assert property (
    !slave_auto && (cfg.rate > 4'h8 || cfg.ratio > 4'hC) |=> config_error)
    else $error("reserved code not flagged");
  slave_len_a: assert property (
    slave_auto && step && !start && !bit_idx[BW-1]
    |=> bit_idx == $past(bit_idx) + ascs_pkg::BITS_ONE)
    else $error("slave automatic used programmed ratio");
  bclk_freq_a: assert property (
    cfg.rate == 4'h4 && !cfg.family && cfg.ratio == 4'h4
    |=> bclk_freq_hz == 32'h002EE000)
    else $error("bit clock frequency mismatch");
  pll_custom_a: assert property (
    cfg.auto_off |=> !auto_derive && pll_enable == $past(custom_pll_en))
    else $error("custom clock setting not followed");
  ratio_stop_a: assert property (
    master && cfg.ratio > ascs_pkg::RATIO_MAX |=> !bclk_q && bit_idx == '0)
    else $error("reserved ratio did not stop the bit clock");
  spec_ref_a: assert property (
    ref_clock_spec_mode && !rate_ok |=> ref_freq_hz == '0)
    else $error("reference rate ignored the frame sync multiple");
  frame_wrap_a: assert property (
    master && !slave_auto && step && bit_idx == ratio_len - 12'h001
    |=> bit_idx == '0)
    else $error("frame length differs from the ratio");

  master_run_c: cover property (run_m && step ##[1:8] frame_sync_out);
  second_line_c: cover property (secondary_serial_oe);
  slave_frame_c: cover property (slave_auto && fs_rise_s);
  gated_c: cover property (master && cfg.gate && bclk_q);
endmodule // ascs_top

/* sim/ascs_host_model.sv */
// Purpose: Host audio processor model at the far side of the serial pins.
// Assumes: Data is taken at bit clock rising edges, as a real host does.
// Notes:   Clocks are made only in slave role and stand still otherwise.
`timescale 1ns/10ps
module ascs_host_model #(
  parameter int GEN_LEN = 64
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Role and framing.
  input wire logic slave_en,
  input wire logic start_on_fall,
  // Pin levels.
  input wire logic bclk_w,
  input wire logic fs_w,
  input wire logic p_w,
  input wire logic p_oe,
  input wire logic s_w,
  input wire logic s_oe,
  // Clocks made in slave role.
  output logic host_bclk,
  output logic host_fs,
  // Last complete frame.
  output int frames,
  output logic [11:0] frame_len,
  output logic [11:0] cap_start,
  output logic [11:0] cap_bits,
  output logic [31:0] cap_word,
  output logic cap_sec
);
  logic bq;
  logic fq;
  logic [1:0] hc;
  logic [11:0] gidx;
  logic [11:0] idx;
  logic [11:0] a_start;
  logic [11:0] a_bits;
  logic [31:0] a_word;
  logic a_sec;

  // Eight cycle bit clock; frame sync is high for the first bit only.
  always @(posedge clk) begin
    if (sys_rst || !slave_en) begin
      hc <= 2'h0;
      host_bclk <= 1'b0;
      host_fs <= 1'b0;
      gidx <= 12'h000;
    end else begin
      hc <= hc + 2'h1;
      if (hc == 2'h3) begin
        host_bclk <= !host_bclk;
      end
      if (hc == 2'h3 && host_bclk) begin
        gidx <= (gidx == GEN_LEN - 1) ? 12'h000 : gidx + 12'h001;
        host_fs <= (gidx == GEN_LEN - 1);
      end
    end
  end

  // The index counts from the frame start edge, so a late slot shows up.
  always @(posedge clk) begin : cap
    logic st;
    logic [11:0] n;
    bq <= bclk_w;
    if (sys_rst) begin
      frames <= 0;
      idx <= 12'h000;
      fq <= 1'b0;
      a_bits = 12'h000;
    end else if (bclk_w && !bq) begin
      st = start_on_fall ? (fq && !fs_w) : (!fq && fs_w);
      n = st ? 12'h000 : idx + 12'h001;
      fq <= fs_w;
      idx <= n;
      if (st) begin
        frames <= frames + 1;
        frame_len <= idx + 12'h001;
        cap_start <= a_start;
        cap_bits <= a_bits;
        cap_word <= a_word;
        cap_sec <= a_sec;
        a_bits = 12'h000;
      end
      if (p_oe || s_oe) begin
        a_start = (a_bits == 12'h000) ? n : a_start;
        a_word = {a_word[30:0], s_oe ? s_w : p_w};
        a_sec = s_oe;
        a_bits = a_bits + 12'h001;
      end
    end
  end
endmodule // ascs_host_model

/* sim/audio_serial_clock_slot_config_tb_top.sv */
// Purpose: Self-checking bench for channel 8 slot and master clocking.
// Assumes: A half bit tick every four cycles; the host captures slots.
// Notes:   Random setups come from a fixed seed, so every run repeats.
`timescale 1ns/10ps
module audio_serial_clock_slot_config_tb_top;
  logic clk, sys_rst, reg_wr, reg_rd, reg_rvalid, sample_taken;
  logic ref_clock_spec_mode, custom_pll_en, half_bit_tick, bclk_in;
  logic frame_sync_in, bclk_out, bclk_oe, frame_sync_out, frame_sync_oe;
  logic primary_serial_out, primary_serial_oe, secondary_serial_out;
  logic secondary_serial_oe, auto_derive, pll_enable, config_error;
  logic slave_en, sof, host_bclk, host_fs, cap_sec;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [5:0] word_bits;
  logic [2:0] ref_ratio_sel;
  logic [1:0] tc;
  logic [11:0] frame_len, cap_start, cap_bits;
  logic [31:0] ch8_sample, fs_hz, bclk_freq_hz, ref_freq_hz, cap_word;
  ascs_pkg::ascs_fmt_e fmt;
  int seed, error_cnt, num_checks, frames, takes;

  // The clock pins carry the device drive in master role, else the host.
  assign bclk_in = bclk_oe ? bclk_out : host_bclk;
  assign frame_sync_in = frame_sync_oe ? frame_sync_out : host_fs;

  ascs_top dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rvalid, .fmt, .word_bits, .ref_clock_spec_mode,
    .ref_ratio_sel, .custom_pll_en, .half_bit_tick, .ch8_sample,
    .sample_taken, .bclk_in, .bclk_out, .bclk_oe, .frame_sync_in,
    .frame_sync_out, .frame_sync_oe, .primary_serial_out,
    .primary_serial_oe, .secondary_serial_out, .secondary_serial_oe,
    .auto_derive, .pll_enable, .fs_hz, .bclk_freq_hz, .ref_freq_hz,
    .config_error);

  ascs_host_model #(.GEN_LEN(64)) host (.clk, .sys_rst, .slave_en,
    .start_on_fall(sof), .bclk_w(bclk_in), .fs_w(frame_sync_in),
    .p_w(primary_serial_out), .p_oe(primary_serial_oe),
    .s_w(secondary_serial_out), .s_oe(secondary_serial_oe), .host_bclk,
    .host_fs, .frames, .frame_len, .cap_start, .cap_bits, .cap_word,
    .cap_sec);

  // Free running clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = !clk;
  end

  // Frame starts that latched a sample, for the sample strobe check.
  always @(posedge clk) begin
    if (sys_rst) takes <= 0;
    else if (sample_taken === 1'b1) takes <= takes + 1;
  end

  // Ticks four cycles apart keep the bit clock well above the minimum.
  always @(posedge clk) begin
    tc <= tc + 2'h1;
    half_bit_tick <= (tc == 2'h3);
  end

  function automatic logic [31:0] fs_of(input logic fam, input logic [3:0] c);
    int k [9] = '{8, 16, 24, 32, 48, 96, 192, 384, 768};
    if (c > 4'h8) return 32'h0;
    return fam ? k[c] * 147000 / 160 : k[c] * 1000;
  endfunction

  function automatic logic [31:0] ratio_of(input logic [3:0] c);
    int r [13] = '{16, 24, 32, 48, 64, 96, 128, 192, 256, 384, 512, 1024,
      2048};
    return (c > 4'hC) ? 32'h0 : r[c];
  endfunction

  function automatic logic [31:0] ref_of(input logic sp, input logic [2:0] c,
      input logic [2:0] s, input logic [31:0] fs);
    int m [8] = '{12000000, 12288000, 13000000, 16000000, 19200000,
      19680000, 24000000, 24576000};
    int q [8] = '{64, 256, 384, 512, 768, 1024, 1536, 2304};
    return sp ? fs * q[s] : m[c];
  endfunction

  // Right slots of the two-slot formats count from half the frame.
  function automatic logic [11:0] start_of(input logic [1:0] f,
      input logic [5:0] sl, input logic [11:0] len, input logic [5:0] w);
    logic [11:0] b;
    b = (f == 2'b00 || sl < 6'h20) ? sl * w : len / 2 + (sl - 6'h20) * w;
    return b + {11'h000, f == 2'b01};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands for exactly the cycle after the request is taken.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rvalid", reg_rvalid, 1'b1);
    chk("reg_rdata", reg_rdata, e);
  endtask

  task automatic frame_run(input logic [1:0] f, input logic [5:0] sl,
      input logic ln, input logic [7:0] c1, input logic [11:0] len,
      input logic [5:0] w);
    int f0;
    int k;
    int t0;
    logic [31:0] msk;
    wr(8'h14, c1);
    wr(8'h12, {1'b0, ln, sl});
    @(posedge clk);
    fmt <= ascs_pkg::ascs_fmt_e'(f);
    word_bits <= w;
    ch8_sample <= $random(seed);
    sof <= (f == 2'b01);
    settle(1);
    f0 = frames;
    k = 0;
    t0 = -1;
    while (frames < f0 + 3 && k < 20000) begin
      settle(1);
      k++;
      if (frames == f0 + 1 && t0 < 0) t0 = takes;
    end
    chk("frame_wait", k < 20000, 1'b1);
    chk("sample_taken", takes - t0, 2);
    msk = 32'hFFFFFFFF >> (6'h20 - w);
    chk("frame_len", frame_len, len);
    chk("slot_start", cap_start, start_of(f, sl, len, w));
    chk("slot_bits", cap_bits, w);
    chk("slot_word", cap_word & msk, ch8_sample & msk);
    chk("out_line", cap_sec, ln);
    $display("Frame test format %0d slot %0d ended", f, sl);
  endtask

  task automatic results;
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    results();
  end

  // Main sequence: registers, clock plan, gating, frames, slave role.
  initial begin
    logic [7:0] sh [3];
    logic [7:0] a, c0, c1, d;
    logic [5:0] w, sl;
    logic [31:0] fx;
    int wl [4] = '{16, 20, 24, 32};
    int n;
    seed = 82642;
    {error_cnt, num_checks} = {32'h0, 32'h0};
    {sys_rst, reg_wr, reg_rd, slave_en, sof} = 5'h10;
    {reg_addr, reg_wdata, tc, half_bit_tick} = 19'h0;
    {ref_clock_spec_mode, custom_pll_en, ref_ratio_sel} = 5'h0;
    fmt = ascs_pkg::ASCS_TDM;
    word_bits = 6'h10;
    ch8_sample = 32'h0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h12, 8'h07);
    rd(8'h13, 8'h02);
    rd(8'h14, 8'h48);
    sh = '{8'h07, 8'h02, 8'h48};
    for (int i = 0; i < 12; i++) begin
      a = 8'h12 + 8'(i % 3);
      d = 8'($random(seed)) | 8'h80;
      wr(a, d);
      sh[i % 3] = (i % 3 == 0) ? d & 8'h7F : d;
      wr(8'h15, d);
      rd(a, sh[i % 3]);
    end
    rd(8'h15, 8'h00);
    $display("Register test ended");
    for (int i = 0; i < 32; i++) begin
      c0 = {3'($random(seed)), 2'($random(seed)), 3'(i)};
      c1 = {4'(i), 4'(i * 7)};
      @(posedge clk);
      ref_clock_spec_mode <= i[3];
      ref_ratio_sel <= 3'($random(seed));
      custom_pll_en <= i[4];
      wr(8'h13, c0);
      wr(8'h14, c1);
      settle(3);
      fx = fs_of(c0[3], c1[7:4]);
      n = !c0[7] && !c0[6];
      chk("auto_derive", auto_derive, !c0[6]);
      chk("pll_enable", pll_enable, c0[6] ? custom_pll_en : !c0[5]);
      chk("bclk_oe", bclk_oe, c0[7]);
      chk("frame_sync_oe", frame_sync_oe, c0[7]);
      chk("config_error", config_error,
        n == 0 && (c1[7:4] > 4'h8 || c1[3:0] > 4'hC));
      if (n == 0) chk("fs_hz", fs_hz, fx);
      if (n == 0) chk("bclk_hz", bclk_freq_hz, fx * ratio_of(c1[3:0]));
      if (c0[7:6] == 2'b10) chk("ref_freq_hz", ref_freq_hz,
        ref_of(ref_clock_spec_mode, c0[2:0], ref_ratio_sel, fx));
    end
    $display("Clock plan test ended");
    wr(8'h14, 8'h44);
    wr(8'h13, 8'h90);
    for (int j = 0; j < 2; j++) begin
      settle(4);
      n = 0;
      repeat (64) begin
        settle(1);
        n += int'(bclk_out | frame_sync_out);
      end
      chk("clock_activity", n > 0, j == 1);
      wr(8'h13, 8'h80);
    end
    $display("Gate test ended");
    frame_run(2'b00, 6'h00, 1'b0, 8'h40, 12'h010, 6'h10);
    frame_run(2'b00, 6'h03, 1'b1, 8'h44, 12'h040, 6'h10);
    frame_run(2'b10, 6'h20, 1'b0, 8'h44, 12'h040, 6'h10);
    frame_run(2'b10, 6'h01, 1'b1, 8'h44, 12'h040, 6'h10);
    frame_run(2'b01, 6'h00, 1'b0, 8'h44, 12'h040, 6'h10);
    frame_run(2'b01, 6'h20, 1'b1, 8'h44, 12'h040, 6'h10);
    for (int i = 0; i < 4; i++) begin
      w = 6'(wl[i]);
      a = 8'({$random(seed)} % 3);
      sl = 6'({$random(seed)} % (64 / wl[i] - 1));
      if (a != 8'h00 && $random(seed) % 2 != 0) sl = sl + 6'h20;
      frame_run(a[1:0], sl, 1'($random(seed)), 8'h46, 12'h080, w);
    end
    wr(8'h13, 8'h02);
    slave_en <= 1'b1;
    frame_run(2'b00, 6'h02, 1'b0, 8'hF4, 12'h040, 6'h10);
    chk("slave_error", config_error, 1'b0);
    chk("slave_bclk_oe", bclk_oe, 1'b0);
    $display("Slave test ended");
    results();
  end
endmodule // audio_serial_clock_slot_config_tb_top
